// ### core/dual_synth_program_latches.sv
// Serial programming latches and output control of the dual synthesizer.
`default_nettype none
`timescale 1ns/10ps
module dual_synth_program_latches (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        serialClock,
	input  wire logic        serialData,
	input  wire logic        latchStrobe,
	input  wire logic        ifLocked,
	input  wire logic        rfLocked,
	input  wire logic        ifPhaseErr,
	input  wire logic        rfPhaseErr,
	output logic      [14:0] ifRefDivide,
	output logic      [5:0]  ifSwallowCount,
	output logic      [11:0] ifProgCount,
	output logic      [1:0]  ifPrescaleSel,
	output logic             ifPdPolarity,
	output logic             ifPumpTristate,
	output logic      [2:0]  ifPumpCurrent,
	output logic             ifDividerLoad,
	output logic             ifInputDebiased,
	output logic             ifPoweredDown,
	output logic      [14:0] rfRefDivide,
	output logic      [5:0]  rfSwallowCount,
	output logic      [11:0] rfProgCount,
	output logic      [1:0]  rfPrescaleSel,
	output logic             rfPdPolarity,
	output logic             rfPumpTristate,
	output logic      [2:0]  rfPumpCurrent,
	output logic             rfDividerLoad,
	output logic             rfInputDebiased,
	output logic             rfPoweredDown,
	output logic             refOscEnable,
	output logic             multiplexedStatusPinOut,
	output logic             multiplexedStatusPinOeN,
	output logic             fastSettlePinOut,
	output logic             fastSettlePinOeN,
	output logic             outputsActive
);
	localparam int W = synth_pkg::WORD_W;

	logic [W-1:0] shiftWord;

	// Strobe synchroniser and edge memory.
	logic strobeMeta_reg;
	logic strobeMeta_next;
	logic strobeSync_reg;
	logic strobeSync_next;
	logic strobeSeen_reg;
	logic strobeSeen_next;
	logic strobeRise;

	// Lock and phase-error synchronisers, {rfErr, ifErr, rfLock, ifLock}.
	logic [3:0] statusMeta_reg;
	logic [3:0] statusMeta_next;
	logic [3:0] statusSync_reg;
	logic [3:0] statusSync_next;

	// Programming latches.
	logic [W-1:0] latch_reg [synth_pkg::LATCH_COUNT];
	logic [W-1:0] latch_next [synth_pkg::LATCH_COUNT];
	logic [3:0]   written_reg;
	logic [3:0]   written_next;
	logic         active_reg;
	logic         active_next;

	// Registered pins.
	logic         multiplexed_status_pin_reg;
	logic         multiplexed_status_pin_next;
	logic         muxOeN_reg;
	logic         muxOeN_next;
	logic         fastOeN_reg;
	logic         fastOeN_next;
	logic         osc_reg;
	logic         osc_next;

	logic [3:0]   muxMode;
	logic         ifAld;
	logic         rfAld;

	section_if ifSec ();
	section_if rfSec ();

	// Picks a single bit out of a latch; used for every loose control bit except the two polarity bits.
	function automatic logic latchBit(input logic [W-1:0] word, input int pos);
		latchBit = word[pos];
	endfunction

	// True when the status pin mode asks for a counter reset of the section.
	function automatic logic resetWanted(input logic [3:0] mode, input logic [3:0] own);
		resetWanted = (mode == own) || (mode == synth_pkg::MUX_BOTH_RST);
	endfunction

	// Field decoders shared by both sections, so the two always read the same positions.
	function automatic logic [14:0] refDivideOf(input logic [W-1:0] word);
		refDivideOf = word[synth_pkg::RDIV_MSB:synth_pkg::RDIV_LSB];
	endfunction

	function automatic logic [5:0] swallowOf(input logic [W-1:0] word);
		swallowOf = word[synth_pkg::ACNT_MSB:synth_pkg::ACNT_LSB];
	endfunction

	function automatic logic [11:0] progOf(input logic [W-1:0] word);
		progOf = word[synth_pkg::BCNT_MSB:synth_pkg::BCNT_LSB];
	endfunction

	function automatic logic [1:0] prescaleOf(input logic [W-1:0] word);
		prescaleOf = word[synth_pkg::PRE_MSB:synth_pkg::PRE_LSB];
	endfunction

	// A loop counts as cleanly locked while its lock input is high and no phase error shows.
	function automatic logic cleanLock(input logic locked, input logic phaseErr);
		cleanLock = locked && !phaseErr;
	endfunction

	serial_shifter #(
		.WIDTH       (W)
	) shifter (
		.serialClock (serialClock),
		.serialData  (serialData),
		.shiftWord   (shiftWord)
	);

	section_ctrl ifCtrl (
		.clock (clock),
		.rst   (rst),
		.sec   (ifSec)
	);

	section_ctrl rfCtrl (
		.clock (clock),
		.rst   (rst),
		.sec   (rfSec)
	);

	// The strobe is a pin of the link domain, so it is synchronised here.
	always_comb begin
		strobeMeta_next = latchStrobe;
		strobeSync_next = strobeMeta_reg;
		strobeSeen_next = strobeSync_reg;
		statusMeta_next = {rfPhaseErr, ifPhaseErr, rfLocked, ifLocked};
		statusSync_next = statusMeta_reg;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			strobeMeta_reg <= 1'b0;
			strobeSync_reg <= 1'b0;
			strobeSeen_reg <= 1'b0;
			statusMeta_reg <= 4'h0;
			statusSync_reg <= 4'h0;
		end else begin
			strobeMeta_reg <= strobeMeta_next;
			strobeSync_reg <= strobeSync_next;
			strobeSeen_reg <= strobeSeen_next;
			statusMeta_reg <= statusMeta_next;
			statusSync_reg <= statusSync_next;
		end
	end

	assign strobeRise = strobeSync_reg && !strobeSeen_reg;

	// The shift word is read only after the strobe has passed the synchroniser.
	// The host stops the link clock while the strobe is high, so the word is stable.
	always_comb begin
		for (int i = 0; i < synth_pkg::LATCH_COUNT; i++) begin
			latch_next[i] = latch_reg[i];
		end
		written_next = written_reg;
		if (strobeRise) begin
			unique case (shiftWord[synth_pkg::SEL_HI_POS:synth_pkg::SEL_LO_POS])
				synth_pkg::SEL_IF_REF: begin
					latch_next[0] = shiftWord;
					written_next[0] = 1'b1;
				end
				synth_pkg::SEL_IF_FB: begin
					latch_next[1] = shiftWord;
					written_next[1] = 1'b1;
				end
				synth_pkg::SEL_RF_REF: begin
					latch_next[2] = shiftWord;
					written_next[2] = 1'b1;
				end
				synth_pkg::SEL_RF_FB: begin
					latch_next[3] = shiftWord;
					written_next[3] = 1'b1;
				end
			endcase
		end
		active_next = &written_reg;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < synth_pkg::LATCH_COUNT; i++) begin
				latch_reg[i] <= synth_pkg::LATCH_RESET;
			end
			written_reg <= 4'h0;
			active_reg  <= 1'b0;
		end else begin
			for (int i = 0; i < synth_pkg::LATCH_COUNT; i++) begin
				latch_reg[i] <= latch_next[i];
			end
			written_reg <= written_next;
			active_reg  <= active_next;
		end
	end

	assign muxMode = {
		latchBit(latch_reg[2], synth_pkg::MODE_HI_POS),
		latchBit(latch_reg[2], synth_pkg::MODE_LO_POS),
		latchBit(latch_reg[0], synth_pkg::MODE_HI_POS),
		latchBit(latch_reg[0], synth_pkg::MODE_LO_POS)
	};

	// Section settings; power-down bits act through the sequencer in each section.
	assign ifSec.pdBit        = latchBit(latch_reg[1], synth_pkg::PD_POS);
	assign ifSec.tristateBit  = latchBit(latch_reg[0], synth_pkg::TRI_POS);
	assign ifSec.gainBit      = latchBit(latch_reg[1], synth_pkg::GAIN_POS);
	assign ifSec.currentField = latch_reg[0][synth_pkg::CUR_MSB:synth_pkg::CUR_LSB];
	assign ifSec.counterReset = resetWanted(muxMode, synth_pkg::MUX_IF_CNT_RST);
	assign ifSec.allWritten   = active_reg;
	assign rfSec.pdBit        = latchBit(latch_reg[3], synth_pkg::PD_POS);
	assign rfSec.tristateBit  = latchBit(latch_reg[2], synth_pkg::TRI_POS);
	assign rfSec.gainBit      = latchBit(latch_reg[3], synth_pkg::GAIN_POS);
	assign rfSec.currentField = latch_reg[2][synth_pkg::CUR_MSB:synth_pkg::CUR_LSB];
	assign rfSec.counterReset = resetWanted(muxMode, synth_pkg::MUX_RF_CNT_RST);
	assign rfSec.allWritten   = active_reg;

	// The lock pulses are sampled at the system rate, so pulses shorter than one
	// period may be missed; the pin then stays high for that comparison.
	assign ifAld = cleanLock(statusSync_reg[0], statusSync_reg[2]);
	assign rfAld = cleanLock(statusSync_reg[1], statusSync_reg[3]);

	always_comb begin
		multiplexed_status_pin_next = 1'b0;
		muxOeN_next = 1'b0;
		unique case (muxMode)
			synth_pkg::MUX_LOW: begin
				multiplexed_status_pin_next = 1'b0;
			end
			synth_pkg::MUX_IF_ALD: begin
				multiplexed_status_pin_next = ifAld;
			end
			synth_pkg::MUX_RF_ALD: begin
				multiplexed_status_pin_next = rfAld;
			end
			synth_pkg::MUX_BOTH_ALD: begin
				multiplexed_status_pin_next = ifAld && rfAld;
			end
			synth_pkg::MUX_IF_CNT_RST, synth_pkg::MUX_RF_CNT_RST, synth_pkg::MUX_BOTH_RST: begin
				multiplexed_status_pin_next = 1'b0;
			end
			synth_pkg::MUX_FASTLOCK: begin
				muxOeN_next = !latchBit(latch_reg[3], synth_pkg::GAIN_POS);
			end
			synth_pkg::MUX_HIGH: begin
				multiplexed_status_pin_next = 1'b1;
			end
			default: begin
				muxOeN_next = 1'b1;
			end
		endcase
		if (!active_reg) begin
			multiplexed_status_pin_next = 1'b0;
			muxOeN_next = 1'b1;
		end
		fastOeN_next = !(active_reg && (ifSec.gainBit || rfSec.gainBit));
		osc_next = !(ifSec.pdBit && rfSec.pdBit);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			multiplexed_status_pin_reg  <= 1'b0;
			muxOeN_reg  <= 1'b1;
			fastOeN_reg <= 1'b1;
			osc_reg     <= 1'b1;
		end else begin
			multiplexed_status_pin_reg  <= multiplexed_status_pin_next;
			muxOeN_reg  <= muxOeN_next;
			fastOeN_reg <= fastOeN_next;
			osc_reg     <= osc_next;
		end
	end

	// Divider settings come straight from the latch flip-flops.
	assign ifRefDivide    = refDivideOf(latch_reg[0]);
	assign ifSwallowCount = swallowOf(latch_reg[1]);
	assign ifProgCount    = progOf(latch_reg[1]);
	assign ifPrescaleSel  = prescaleOf(latch_reg[1]);
	assign ifPdPolarity   = latch_reg[0][synth_pkg::POL_POS];
	assign rfRefDivide    = refDivideOf(latch_reg[2]);
	assign rfSwallowCount = swallowOf(latch_reg[3]);
	assign rfProgCount    = progOf(latch_reg[3]);
	assign rfPrescaleSel  = prescaleOf(latch_reg[3]);
	assign rfPdPolarity   = latch_reg[2][synth_pkg::POL_POS];

	assign ifPumpTristate  = ifSec.pumpTristate;
	assign ifPumpCurrent   = ifSec.pumpCurrent;
	assign ifDividerLoad   = ifSec.dividerLoad;
	assign ifInputDebiased = ifSec.debiased;
	assign ifPoweredDown   = ifSec.poweredDown;
	assign rfPumpTristate  = rfSec.pumpTristate;
	assign rfPumpCurrent   = rfSec.pumpCurrent;
	assign rfDividerLoad   = rfSec.dividerLoad;
	assign rfInputDebiased = rfSec.debiased;
	assign rfPoweredDown   = rfSec.poweredDown;

	assign refOscEnable            = osc_reg;
	assign multiplexedStatusPinOut = multiplexed_status_pin_reg;
	assign multiplexedStatusPinOeN = muxOeN_reg;
	// The fast settle pin only ever pulls low; its enable alone carries the state.
	assign fastSettlePinOut        = 1'b0;
	assign fastSettlePinOeN        = fastOeN_reg;
	assign outputsActive           = active_reg;
endmodule // dual_synth_program_latches
`default_nettype wire

// ### core/section_ctrl.sv
// Power-down sequencing and pump control for one synthesizer section.
`default_nettype none
`timescale 1ns/10ps
module section_ctrl (
	input  wire logic clock,
	input  wire logic rst,
	section_if.ctrl   sec
);
	synth_pkg::pd_state_e state_reg;
	synth_pkg::pd_state_e state_next;
	logic [3:0]           quiet_reg;
	logic [3:0]           quiet_next;
	logic                 tri_reg;
	logic                 tri_next;
	logic [2:0]           cur_reg;
	logic [2:0]           cur_next;
	logic                 load_reg;
	logic                 load_next;
	logic                 down_reg;
	logic                 down_next;

	always_comb begin
		state_next = state_reg;
		quiet_next = quiet_reg;
		unique case (state_reg)
			synth_pkg::PD_ACTIVE: begin
				if (sec.pdBit && sec.tristateBit) begin
					state_next = synth_pkg::PD_DOWN;
				end else if (sec.pdBit) begin
					state_next = synth_pkg::PD_QUIET;
					quiet_next = synth_pkg::PUMP_QUIET_CYCLES;
				end
			end
			synth_pkg::PD_QUIET: begin
				if (!sec.pdBit) begin
					state_next = synth_pkg::PD_ACTIVE;
				end else if (quiet_reg == 4'h0) begin
					state_next = synth_pkg::PD_DOWN;
				end else begin
					quiet_next = quiet_reg - 4'h1;
				end
			end
			synth_pkg::PD_DOWN: begin
				if (!sec.pdBit) begin
					state_next = synth_pkg::PD_ACTIVE;
				end
			end
			default: begin
				state_next = synth_pkg::PD_ACTIVE;
			end
		endcase
		// On power-down the pump is quieted before the dividers are loaded, so no stray charge lands.
		tri_next = sec.tristateBit || sec.counterReset || !sec.allWritten
			|| (state_next != synth_pkg::PD_ACTIVE);
		cur_next = sec.gainBit ? synth_pkg::PUMP_MAX : sec.currentField;
		// One signal holds R and A/B together, so they release on the same edge.
		load_next = sec.counterReset || !sec.allWritten
			|| (state_next == synth_pkg::PD_DOWN);
		down_next = (state_next == synth_pkg::PD_DOWN);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= synth_pkg::PD_ACTIVE;
			quiet_reg <= 4'h0;
			tri_reg   <= 1'b1;
			cur_reg   <= 3'h0;
			load_reg  <= 1'b1;
			down_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			quiet_reg <= quiet_next;
			tri_reg   <= tri_next;
			cur_reg   <= cur_next;
			load_reg  <= load_next;
			down_reg  <= down_next;
		end
	end

	assign sec.pumpTristate = tri_reg;
	assign sec.pumpCurrent  = cur_reg;
	assign sec.dividerLoad  = load_reg;
	assign sec.debiased     = down_reg;
	assign sec.poweredDown  = down_reg;
endmodule // section_ctrl
`default_nettype wire

// ### core/section_if.sv
// Settings and results passed between the top and one synthesizer section.
`default_nettype none
`timescale 1ns/10ps
interface section_if;
	logic       pdBit;
	logic       tristateBit;
	logic       gainBit;
	logic [2:0] currentField;
	logic       counterReset;
	logic       allWritten;
	logic       pumpTristate;
	logic [2:0] pumpCurrent;
	logic       dividerLoad;
	logic       debiased;
	logic       poweredDown;

	modport ctrl (
		input  pdBit, tristateBit, gainBit, currentField, counterReset, allWritten,
		output pumpTristate, pumpCurrent, dividerLoad, debiased, poweredDown
	);
	modport top (
		output pdBit, tristateBit, gainBit, currentField, counterReset, allWritten,
		input  pumpTristate, pumpCurrent, dividerLoad, debiased, poweredDown
	);
endinterface
`default_nettype wire

// ### core/serial_shifter.sv
// Input shift register clocked by the serial link clock.
`default_nettype none
`timescale 1ns/10ps
module serial_shifter #(
	parameter int WIDTH = synth_pkg::WORD_W
) (
	input  wire logic             serialClock,
	input  wire logic             serialData,
	output logic      [WIDTH-1:0] shiftWord
);
	logic [WIDTH-1:0] shift_reg;
	logic [WIDTH-1:0] shift_next;

	// The shifter has no reset because the link clock only runs inside frames.
	always_comb begin
		shift_next = {shift_reg[WIDTH-2:0], serialData};
	end

	always_ff @(posedge serialClock) begin
		shift_reg <= shift_next;
	end

	assign shiftWord = shift_reg;
endmodule // serial_shifter
`default_nettype wire

// ### core/synth_pkg.sv
// Shared constants for the dual synthesizer programming logic.
`default_nettype none
package synth_pkg;
	localparam int WORD_W = 24;
	localparam int LATCH_COUNT = 4;

	// Latch select codes carried in the two least significant word bits.
	localparam logic [1:0] SEL_IF_REF = 2'h0;
	localparam logic [1:0] SEL_IF_FB  = 2'h1;
	localparam logic [1:0] SEL_RF_REF = 2'h2;
	localparam logic [1:0] SEL_RF_FB  = 2'h3;
	localparam int SEL_LO_POS = 0;
	localparam int SEL_HI_POS = 1;

	// Reference latch layout.
	localparam int CUR_MSB     = 23;
	localparam int CUR_LSB     = 21;
	localparam int MODE_HI_POS = 20;
	localparam int MODE_LO_POS = 19;
	localparam int TRI_POS     = 18;
	localparam int POL_POS     = 17;
	localparam int RDIV_MSB    = 16;
	localparam int RDIV_LSB    = 2;

	// Feedback latch layout.
	localparam int GAIN_POS  = 23;
	localparam int PD_POS    = 22;
	localparam int PRE_MSB   = 21;
	localparam int PRE_LSB   = 20;
	localparam int BCNT_MSB  = 19;
	localparam int BCNT_LSB  = 8;
	localparam int ACNT_MSB  = 7;
	localparam int ACNT_LSB  = 2;

	localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;
	localparam logic [2:0] PUMP_MAX = 3'h7;
	localparam logic [3:0] PUMP_QUIET_CYCLES = 4'h4;

	// Status pin modes, built as {rf mode hi, rf mode lo, if mode hi, if mode lo}.
	localparam logic [3:0] MUX_LOW        = 4'h0;
	localparam logic [3:0] MUX_IF_ALD     = 4'h1;
	localparam logic [3:0] MUX_RF_ALD     = 4'h2;
	localparam logic [3:0] MUX_BOTH_ALD   = 4'h3;
	localparam logic [3:0] MUX_IF_CNT_RST = 4'h4;
	localparam logic [3:0] MUX_RF_CNT_RST = 4'h5;
	localparam logic [3:0] MUX_BOTH_RST   = 4'h6;
	localparam logic [3:0] MUX_FASTLOCK   = 4'h7;
	localparam logic [3:0] MUX_HIGH       = 4'h8;

	typedef enum logic [1:0] {
		PD_ACTIVE  = 2'h0,
		PD_QUIET   = 2'h1,
		PD_DOWN    = 2'h3
	} pd_state_e;
endpackage
`default_nettype wire

// ### verif/dual_synth_program_latches_bench.sv
// Self-checking bench comparing the programming latches with a word-level model.
`default_nettype none
`timescale 1ns/10ps
module dual_synth_program_latches_bench;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        ifLocked = 1'b0, rfLocked = 1'b0, ifPhaseErr = 1'b0, rfPhaseErr = 1'b0;
	wire logic   serialClock, serialData, latchStrobe;
	logic [14:0] ifRefDivide, rfRefDivide;
	logic [11:0] ifProgCount, rfProgCount;
	logic [5:0]  ifSwallowCount, rfSwallowCount;
	logic [2:0]  ifPumpCurrent, rfPumpCurrent;
	logic [1:0]  ifPrescaleSel, rfPrescaleSel;
	logic        ifPdPolarity, ifPumpTristate, ifDividerLoad, ifInputDebiased, ifPoweredDown;
	logic        rfPdPolarity, rfPumpTristate, rfDividerLoad, rfInputDebiased, rfPoweredDown;
	logic        refOscEnable, multiplexedStatusPinOut, multiplexedStatusPinOeN;
	logic        fastSettlePinOut, fastSettlePinOeN, outputsActive;
	int          mismatches = 0;
	int          checks = 0;
	logic [31:0] seed = 32'hce46e2a9;
	logic [23:0] latchModel [4] = '{default: 24'h000000};
	logic [3:0]  writtenMask = 4'h0;

	always #12.5 clock = ~clock;

	host_serial_master host (.serialClock, .serialData, .latchStrobe);

	dual_synth_program_latches uut (.clock, .rst, .serialClock, .serialData, .latchStrobe,
		.ifLocked, .rfLocked, .ifPhaseErr, .rfPhaseErr, .ifRefDivide, .ifSwallowCount,
		.ifProgCount, .ifPrescaleSel, .ifPdPolarity, .ifPumpTristate, .ifPumpCurrent,
		.ifDividerLoad, .ifInputDebiased, .ifPoweredDown, .rfRefDivide, .rfSwallowCount,
		.rfProgCount, .rfPrescaleSel, .rfPdPolarity, .rfPumpTristate, .rfPumpCurrent,
		.rfDividerLoad, .rfInputDebiased, .rfPoweredDown, .refOscEnable,
		.multiplexedStatusPinOut, .multiplexedStatusPinOeN, .fastSettlePinOut,
		.fastSettlePinOeN, .outputsActive);

	function automatic logic [31:0] nextRand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic checkField(input logic [31:0] expVal, input logic [31:0] gotVal);
		checks++;
		if (expVal !== gotVal) begin
			mismatches++;
			$display("unexpected field at %0t: expected %h got %h", $time, expVal, gotVal);
		end
	endtask

	task automatic checkFlag(input logic expVal, input logic gotVal);
		checks++;
		if (expVal !== gotVal) begin
			mismatches++;
			$display("unexpected flag at %0t: expected %h got %h", $time, expVal, gotVal);
		end
	endtask

	task automatic checkAll();
		logic       act, ifPd, rfPd, ifG, rfG, ifRst, rfRst, expOut, expOeN;
		logic [3:0] mode;
		act = &writtenMask;
		mode = {latchModel[2][20:19], latchModel[0][20:19]};
		ifPd = latchModel[1][22];
		rfPd = latchModel[3][22];
		ifG = latchModel[1][23];
		rfG = latchModel[3][23];
		ifRst = mode == 4'h4 || mode == 4'h6;
		rfRst = mode == 4'h5 || mode == 4'h6;
		expOeN = 1'b1;
		expOut = 1'b0;
		if (act) begin
			case (mode)
				4'h0, 4'h4, 4'h5, 4'h6: expOeN = 1'b0;
				4'h1: {expOeN, expOut} = {1'b0, ifLocked && !ifPhaseErr};
				4'h2: {expOeN, expOut} = {1'b0, rfLocked && !rfPhaseErr};
				4'h3: {expOeN, expOut} = {1'b0, ifLocked && rfLocked && !ifPhaseErr && !rfPhaseErr};
				4'h7: expOeN = !rfG;
				4'h8: {expOeN, expOut} = 2'b01;
				default: expOeN = 1'b1;
			endcase
		end
		checkField(latchModel[0][16:2], ifRefDivide);
		checkField({latchModel[1][19:8], latchModel[1][7:2]}, {ifProgCount, ifSwallowCount});
		checkField(latchModel[2][16:2], rfRefDivide);
		checkField({latchModel[3][19:8], latchModel[3][7:2]}, {rfProgCount, rfSwallowCount});
		checkField({latchModel[1][21:20], latchModel[3][21:20]}, {ifPrescaleSel, rfPrescaleSel});
		checkField({latchModel[0][17], latchModel[2][17]}, {ifPdPolarity, rfPdPolarity});
		checkFlag(!act || ifPd || ifRst || latchModel[0][18], ifPumpTristate);
		checkFlag(!act || rfPd || rfRst || latchModel[2][18], rfPumpTristate);
		checkFlag(!act || ifPd || ifRst, ifDividerLoad);
		checkFlag(!act || rfPd || rfRst, rfDividerLoad);
		checkField({ifPd, ifPd, rfPd, rfPd}, {ifPoweredDown, ifInputDebiased, rfPoweredDown, rfInputDebiased});
		if (act) checkField(ifG ? 3'h7 : latchModel[0][23:21], ifPumpCurrent);
		if (act) checkField(rfG ? 3'h7 : latchModel[2][23:21], rfPumpCurrent);
		checkFlag(!(ifPd && rfPd), refOscEnable);
		checkFlag(act, outputsActive);
		checkFlag(!(act && (ifG || rfG)), fastSettlePinOeN);
		checkFlag(1'b0, fastSettlePinOut);
		checkFlag(expOeN, multiplexedStatusPinOeN);
		if (!expOeN) checkFlag(expOut, multiplexedStatusPinOut);
	endtask

	// Reference latches get their mode bits from the caller so every status mode is reached.
	task automatic writeRand(input logic [1:0] sel, input logic [1:0] modeBits,
			input logic [23:0] clearMask);
		logic [31:0] r;
		logic [23:0] w;
		r = nextRand();
		w = {r[23:2], sel} & ~clearMask;
		if (!sel[0]) w[20:19] = modeBits;
		@(posedge clock);
		{ifLocked, rfLocked, ifPhaseErr, rfPhaseErr} <= r[31:28];
		host.sendWord(w);
		latchModel[sel] = w;
		writtenMask[sel] = 1'b1;
		repeat (10) @(negedge clock);
		checkAll();
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		complete_run();
	end

	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(negedge clock);
		checkAll();
		for (int s = 0; s < 3; s++) writeRand(s[1:0], 2'h0, 24'h400000);
		writeRand(2'h3, 2'h0, 24'h000000);
		for (int m = 0; m < 16; m++) begin
			for (int s = 0; s < 4; s++) writeRand(s[1:0], s[1] ? m[3:2] : m[1:0], 24'h000000);
		end
		// A reset in mid-run must forget every write, so the four writes are needed again.
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		latchModel = '{default: 24'h000000};
		writtenMask = 4'h0;
		repeat (2) @(negedge clock);
		checkAll();
		for (int s = 0; s < 4; s++) writeRand(s[1:0], 2'h1, 24'h000000);
		complete_run();
	end
endmodule // dual_synth_program_latches_bench
`default_nettype wire

// ### verif/dual_synth_program_latches_monitor.sv
// Port-level assertions for the synthesizer programming latches.
`default_nettype none
`timescale 1ns/10ps
module dual_synth_program_latches_monitor (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       ifPumpTristate,
	input wire logic [2:0] ifPumpCurrent,
	input wire logic       ifDividerLoad,
	input wire logic       ifInputDebiased,
	input wire logic       ifPoweredDown,
	input wire logic       rfPumpTristate,
	input wire logic [2:0] rfPumpCurrent,
	input wire logic       rfDividerLoad,
	input wire logic       rfInputDebiased,
	input wire logic       rfPoweredDown,
	input wire logic       refOscEnable,
	input wire logic       multiplexedStatusPinOut,
	input wire logic       multiplexedStatusPinOeN,
	input wire logic       fastSettlePinOut,
	input wire logic       fastSettlePinOeN,
	input wire logic       outputsActive
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_inactive_pins_released: assert property (!outputsActive |-> multiplexedStatusPinOeN && fastSettlePinOeN) else $error("pin driven before all latches written");
	a_inactive_pumps_quiet: assert property (!outputsActive |-> ifPumpTristate && rfPumpTristate && ifDividerLoad && rfDividerLoad) else $error("section live before all latches written");
	a_active_holds: assert property (outputsActive |=> outputsActive) else $error("outputs active dropped");
	a_if_down_loads: assert property (ifPoweredDown |-> ifDividerLoad && ifInputDebiased && ifPumpTristate) else $error("if section down but not loaded");
	a_rf_down_loads: assert property (rfPoweredDown |-> rfDividerLoad && rfInputDebiased && rfPumpTristate) else $error("rf section down but not loaded");
	a_if_quiet_first: assert property ($rose(ifPoweredDown) |-> $past(ifPumpTristate)) else $error("if pump live when section went down");
	a_rf_quiet_first: assert property ($rose(rfPoweredDown) |-> $past(rfPumpTristate)) else $error("rf pump live when section went down");
	a_osc_off_down: assert property ($fell(refOscEnable) |-> ##[0:8] (ifPoweredDown && rfPoweredDown)) else $error("oscillator off without both sections down");
	a_down_osc_off: assert property ((ifPoweredDown && rfPoweredDown) [*2] |-> !refOscEnable) else $error("oscillator on with both sections down");
	a_settle_pulls_low: assert property ((!fastSettlePinOeN) [*2] |-> !fastSettlePinOut && (ifPumpCurrent == 3'h7 || rfPumpCurrent == 3'h7)) else $error("fastlock without maximum pump current");

	c_outputs_active: cover property ($rose(outputsActive));
	c_both_down: cover property (ifPoweredDown && rfPoweredDown);
	c_settle_driven: cover property (!fastSettlePinOeN);
	c_status_high: cover property (!multiplexedStatusPinOeN && multiplexedStatusPinOut);
endmodule // dual_synth_program_latches_monitor

bind dual_synth_program_latches dual_synth_program_latches_monitor monitor (.clock, .rst,
	.ifPumpTristate, .ifPumpCurrent, .ifDividerLoad, .ifInputDebiased, .ifPoweredDown,
	.rfPumpTristate, .rfPumpCurrent, .rfDividerLoad, .rfInputDebiased, .rfPoweredDown,
	.refOscEnable, .multiplexedStatusPinOut, .multiplexedStatusPinOeN, .fastSettlePinOut,
	.fastSettlePinOeN, .outputsActive);
`default_nettype wire

// ### verif/host_serial_master.sv
// Behavioural host that shifts programming words into the synthesizer.
`default_nettype none
`timescale 1ns/10ps
module host_serial_master (
	output logic serialClock,
	output logic serialData,
	output logic latchStrobe
);
	initial begin
		serialClock = 1'b0;
		serialData = 1'b0;
		latchStrobe = 1'b0;
	end

	// The link clock only runs inside a frame, so the device never sees stray edges.
	task automatic sendWord(input logic [23:0] word);
		for (int i = 23; i >= 0; i--) begin
			serialData = word[i];
			#3 serialClock = 1'b1;
			#3 serialClock = 1'b0;
		end
		// A released data line must not keep showing the last bit.
		serialData = ~word[0];
		#20 latchStrobe = 1'b1;
		#100 latchStrobe = 1'b0;
		#100;
	endtask
endmodule // host_serial_master
`default_nettype wire
